// ==== pau_port.sv ====
// Port A pin logic with AXI4-Lite register slave and oscillator-shared upper pins.
// Functional notes
// - Latch drives pin six only in internal oscillator mode without clock output.
// - Pin six reads its level only in internal oscillator mode without clock output.
// - RC mode drives pin six with quarter-rate clock, ignoring the direction bit.
// - External oscillator modes block the latch from driving pin seven.
// - External oscillator modes disable the digital input of pin seven.
// - Unimplemented register bits read zero and ignore writes.
// - Direction one makes input with driver off; zero drives latch onto pin.
// - Latch register reads and writes the latched value, not the pin.
// - Enabled peripheral output outranks the port latch on a pin.
module pau_port
    import pau_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  pad_in,
    output pau_pad_out_t     pad_out,
    output logic [7:0]       slew_limit
);

    // ***********************************************************************
    // Registers
    // ***********************************************************************
    logic [7:0]    latch_ff;
    logic [7:0]    dir_ff;
    logic [7:0]    ansel_ff;
    logic [7:0]    slew_ff;
    logic [2:0]    osc_ff;
    pau_periph_t   periph_ff;
    pau_pad_out_t  pad_ff;
    logic [1:0]    quarter_ff;
    logic          awready_ff;
    logic          wready_ff;
    logic [7:0]    awaddr_ff;
    logic [31:0]   wdata_ff;
    logic [3:0]    wstrb_ff;
    logic          bvalid_ff;
    logic [1:0]    bresp_ff;
    logic          rvalid_ff;
    logic          arready_ff;
    logic [31:0]   rdata_ff;
    logic [1:0]    rresp_ff;
    logic [7:0]    pin_sync;
    logic [7:0]    pin_read;
    logic [7:0]    dig_in_en;
    logic          int_osc;
    logic          clkout_en;
    logic          ext_osc;
    logic          rc_mode;
    logic          do_write;
    logic          nxt_write_ok;
    logic [31:0]   nxt_rdata;
    logic          nxt_read_ok;
    pau_pad_out_t  nxt_pad;

    pau_sync pau_sync_inst
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (pad_in),
        .dout    (pin_sync)
    );

    // ***********************************************************************
    // Oscillator-mode decode
    // ***********************************************************************
    assign rc_mode   = (osc_ff[1:0] == PAU_OSC_RC);
    assign int_osc   = (osc_ff[1:0] == PAU_OSC_INTERNAL);
    assign ext_osc   = !int_osc;
    assign clkout_en = osc_ff[CLKOUT_EN_BIT] || rc_mode;

    // Digital input enables: analog select kills the buffer, the upper pins depend on the oscillator.
    always_comb
    begin
        dig_in_en            = ~ansel_ff;
        dig_in_en[BIT_PIN6]  = int_osc && !clkout_en;
        dig_in_en[BIT_PIN7]  = !ext_osc;
        pin_read             = pin_sync & dig_in_en;
    end

    // ***********************************************************************
    // Pad drive
    // ***********************************************************************
    always_comb
    begin
        for (int i = 0; i < NPINS; i++)
        begin
            if (periph_ff.en[i])
            begin
                nxt_pad.oe[i]   = 1'b1;
                nxt_pad.dout[i] = periph_ff.val[i];
            end
            else
            begin
                nxt_pad.oe[i]   = !dir_ff[i];
                nxt_pad.dout[i] = latch_ff[i];
            end
        end
        // Outside internal mode without clock output the oscillator owns pin six, and outside internal mode pin seven; peripherals and the latch lose them there.
        if (rc_mode)
        begin
            nxt_pad.oe[BIT_PIN6]   = 1'b1;
            nxt_pad.dout[BIT_PIN6] = quarter_ff[1];
        end
        else if (!(int_osc && !clkout_en))
        begin
            nxt_pad.oe[BIT_PIN6]   = 1'b0;
            nxt_pad.dout[BIT_PIN6] = 1'b0;
        end
        if (ext_osc)
        begin
            nxt_pad.oe[BIT_PIN7]   = 1'b0;
            nxt_pad.dout[BIT_PIN7] = 1'b0;
        end
    end

    // The block clock stands in for the oscillator input; bit one of a two-bit count toggles every two cycles.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            quarter_ff <= 2'h0;
        else if (quarter_ff == QUARTER_WRAP)
            quarter_ff <= 2'h0;
        else
            quarter_ff <= quarter_ff + 2'h1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pad_ff     <= '0;
            slew_limit <= SLEW_RESET;
        end
        else
        begin
            pad_ff     <= nxt_pad;
            slew_limit <= slew_ff;
        end
    end

    assign pad_out = pad_ff;

    // ***********************************************************************
    // AXI4-Lite write channel
    // ***********************************************************************
    assign do_write = !awready_ff && !wready_ff && !bvalid_ff;

    always_comb
    begin
        case (awaddr_ff)
            OFF_PIN_LEVEL_A, OFF_OUTPUT_LATCH, OFF_DIRECTION_A, OFF_ANALOG_SEL_A,
            OFF_SLEW_RATE, OFF_OSC_CONFIG, OFF_PERIPH_CTRL: nxt_write_ok = 1'b1;
            default:                                        nxt_write_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            awaddr_ff  <= 8'h00;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && awready_ff)
            begin
                awready_ff <= 1'b0;
                awaddr_ff <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && wready_ff)
            begin
                wready_ff <= 1'b0;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_write)
            begin
                awready_ff <= 1'b1;
                wready_ff  <= 1'b1;
                bvalid_ff  <= 1'b1;
                bresp_ff  <= nxt_write_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_ff && s_axi_bready)
                bvalid_ff <= 1'b0;
        end
    end

    // Writing the pin-level register lands in the latch, as on a classic port.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            latch_ff  <= LATCH_RESET;
            dir_ff    <= DIR_RESET;
            ansel_ff  <= ANSEL_RESET;
            slew_ff   <= SLEW_RESET;
            osc_ff    <= OSC_RESET;
            periph_ff <= {PERIPH_RESET, PERIPH_RESET};
        end
        else if (do_write && wstrb_ff[0])
        begin
            case (awaddr_ff)
                OFF_PIN_LEVEL_A,
                OFF_OUTPUT_LATCH: latch_ff <= wdata_ff[7:0];
                OFF_DIRECTION_A:  dir_ff   <= wdata_ff[7:0];
                OFF_ANALOG_SEL_A: ansel_ff <= wdata_ff[7:0] & ANSEL_IMPL_MASK;
                OFF_SLEW_RATE:    slew_ff  <= wdata_ff[7:0] & SLEW_IMPL_MASK;
                OFF_OSC_CONFIG:   osc_ff   <= wdata_ff[2:0];
                OFF_PERIPH_CTRL:  periph_ff.en <= wdata_ff[PERIPH_EN_LSB +: 8];
                default:          latch_ff <= latch_ff;
            endcase
            if (awaddr_ff == OFF_PERIPH_CTRL && wstrb_ff[1])
                periph_ff.val <= wdata_ff[PERIPH_VAL_LSB +: 8];
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;

    // ***********************************************************************
    // AXI4-Lite read channel
    // ***********************************************************************
    always_comb
    begin
        nxt_read_ok = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            OFF_PIN_LEVEL_A:  nxt_rdata = {24'h0, pin_read};
            OFF_OUTPUT_LATCH: nxt_rdata = {24'h0, latch_ff};
            OFF_DIRECTION_A:  nxt_rdata = {24'h0, dir_ff};
            OFF_ANALOG_SEL_A: nxt_rdata = {24'h0, ansel_ff & ANSEL_IMPL_MASK};
            OFF_SLEW_RATE:    nxt_rdata = {24'h0, slew_ff & SLEW_IMPL_MASK};
            OFF_OSC_CONFIG:   nxt_rdata = {29'h0, osc_ff};
            OFF_PERIPH_CTRL:  nxt_rdata = {16'h0, periph_ff.val, periph_ff.en};
            default:
            begin
                nxt_rdata   = 32'h0000_0000;
                nxt_read_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_ff)
        begin
            rvalid_ff  <= 1'b1;
            arready_ff <= 1'b0;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_read_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            rvalid_ff  <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // ***********************************************************************
    // Assertions
    // ***********************************************************************
    a_pin6_latch_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        (!rc_mode && !(int_osc && !clkout_en)) |=> !pad_ff.oe[BIT_PIN6])
        else $error("pin six driven outside internal oscillator mode");

    a_pin6_read_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && !rvalid_ff && {s_axi_araddr[7:2], 2'b00} == OFF_PIN_LEVEL_A && !(int_osc && !clkout_en))
        |=> !s_axi_rdata[BIT_PIN6])
        else $error("pin six level leaked into read");

    a_rc_clock_out: assert property (@(posedge aclk) disable iff (!aresetn)
        (rc_mode && $past(rc_mode)) |=> (pad_ff.oe[BIT_PIN6] && pad_ff.dout[BIT_PIN6] == $past(quarter_ff[1])))
        else $error("clock output missing on pin six in RC mode");

    a_rc_quarter_rate: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(quarter_ff[1]) |=> quarter_ff[1] ##1 !quarter_ff[1] ##1 !quarter_ff[1] ##1 quarter_ff[1])
        else $error("clock output not at one quarter rate");

    a_pin7_drive_off: assert property (@(posedge aclk) disable iff (!aresetn)
        ext_osc |=> !pad_ff.oe[BIT_PIN7])
        else $error("pin seven driven in external oscillator mode");

    a_pin7_input_off: assert property (@(posedge aclk) disable iff (!aresetn)
        ext_osc |-> !pin_read[BIT_PIN7])
        else $error("pin seven input active in external oscillator mode");

    a_ansel_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
        (ansel_ff & ~ANSEL_IMPL_MASK) == 8'h00 && (slew_ff & ~SLEW_IMPL_MASK) == 8'h00)
        else $error("unimplemented bits hold ones");

    a_dir_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        (!periph_ff.en[0] && !dir_ff[0]) |=> (pad_ff.oe[0] && pad_ff.dout[0] == $past(latch_ff[0])))
        else $error("cleared direction bit does not drive the latch");

    a_latch_readback: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && !rvalid_ff && {s_axi_araddr[7:2], 2'b00} == OFF_OUTPUT_LATCH)
        |=> s_axi_rdata[7:0] == $past(latch_ff))
        else $error("latch read does not return latched value");

    a_periph_prio: assert property (@(posedge aclk) disable iff (!aresetn)
        (periph_ff.en[1] && dir_ff[1]) |=> (pad_ff.oe[1] && pad_ff.dout[1] == $past(periph_ff.val[1])))
        else $error("peripheral does not outrank latch");

    a_ansel_input: assert property (@(posedge aclk) disable iff (!aresetn)
        ansel_ff[3] |-> !pin_read[3])
        else $error("analog pin digital input not disabled");

endmodule

// ==== pau_pkg.sv ====
// Package with register map, field positions, reset values and types of the port A pin block.
package pau_pkg;

    // ***********************************************************************
    // Register map (byte addresses, one aligned word each)
    // ***********************************************************************
    localparam logic [7:0] OFF_PIN_LEVEL_A   = 8'h00;
    localparam logic [7:0] OFF_OUTPUT_LATCH  = 8'h04;
    localparam logic [7:0] OFF_DIRECTION_A   = 8'h08;
    localparam logic [7:0] OFF_ANALOG_SEL_A  = 8'h0C;
    localparam logic [7:0] OFF_SLEW_RATE     = 8'h10;
    localparam logic [7:0] OFF_OSC_CONFIG    = 8'h14;
    localparam logic [7:0] OFF_PERIPH_CTRL   = 8'h18;

    // ***********************************************************************
    // Field layouts and reset values
    // ***********************************************************************
    localparam logic [7:0] ANSEL_IMPL_MASK   = 8'h2F;
    localparam logic [7:0] SLEW_IMPL_MASK    = 8'h1F;
    localparam logic [7:0] OSC_IMPL_MASK     = 8'h07;
    localparam logic [7:0] LATCH_RESET       = 8'h00;
    localparam logic [7:0] DIR_RESET         = 8'hFF;
    localparam logic [7:0] ANSEL_RESET       = 8'h2F;
    localparam logic [7:0] SLEW_RESET        = 8'h1F;
    localparam logic [7:0] PERIPH_RESET      = 8'h00;
    localparam int         OSC_MODE_LSB      = 0;
    localparam int         CLKOUT_EN_BIT     = 2;
    localparam int         BIT_PIN6          = 6;
    localparam int         BIT_PIN7          = 7;
    localparam int         PERIPH_EN_LSB     = 0;
    localparam int         PERIPH_VAL_LSB    = 8;
    localparam int         NPINS             = 8;
    localparam logic [1:0] QUARTER_WRAP      = 2'h3;
    localparam logic [1:0] RESP_OKAY         = 2'h0;
    localparam logic [1:0] RESP_SLVERR       = 2'h2;

    // Oscillator mode selection held in the oscillator configuration register.
    typedef enum logic [1:0]
    {
        PAU_OSC_INTERNAL = 2'h0,
        PAU_OSC_RC       = 2'h1,
        PAU_OSC_EXTERNAL = 2'h2,
        PAU_OSC_CRYSTAL  = 2'h3
    } pau_osc_mode_t;

    localparam logic [2:0] OSC_RESET = {1'b0, PAU_OSC_INTERNAL};

    // Pin bundle toward the pads.
    typedef struct packed
    {
        logic [7:0] dout;
        logic [7:0] oe;
    } pau_pad_out_t;

    // Alternate peripheral outputs that outrank the latch.
    typedef struct packed
    {
        logic [7:0] en;
        logic [7:0] val;
    } pau_periph_t;

endpackage

// ==== pau_sync.sv ====
// Three-stage input synchroniser with agreement filter for the pad inputs.
module pau_sync
    import pau_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [NPINS-1:0] din,
    output logic      [NPINS-1:0] dout
);

    logic [NPINS-1:0] s1_ff;
    logic [NPINS-1:0] s2_ff;
    logic [NPINS-1:0] s3_ff;
    logic [NPINS-1:0] out_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end
        else
        begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // A level is accepted only once stages two and three agree, filtering a one-cycle glitch.
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++)
        begin : g_filt
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    out_ff[gi] <= 1'b0;
                else if (s2_ff[gi] == s3_ff[gi])
                    out_ff[gi] <= s3_ff[gi];
            end
        end
    endgenerate

    assign dout = out_ff;

endmodule

// ==== tb.sv ====
// Self-checking testbench of the port A pin block with its register slave.
module tb
    import pau_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic         aclk;
    logic         aresetn;
    logic [7:0]   s_axi_awaddr;
    logic         s_axi_awvalid;
    logic         s_axi_awready;
    logic [31:0]  s_axi_wdata;
    logic [3:0]   s_axi_wstrb;
    logic         s_axi_wvalid;
    logic         s_axi_wready;
    logic [1:0]   s_axi_bresp;
    logic         s_axi_bvalid;
    logic         s_axi_bready;
    logic [7:0]   s_axi_araddr;
    logic         s_axi_arvalid;
    logic         s_axi_arready;
    logic [31:0]  s_axi_rdata;
    logic [1:0]   s_axi_rresp;
    logic         s_axi_rvalid;
    logic         s_axi_rready;
    logic [7:0]   pad_in;
    pau_pad_out_t pad_out;
    logic [7:0]   slew_limit;
    int           n_errors;
    int           n_checks;
    int           cycles;

    pau_port pau_port_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pad_in(pad_in), .pad_out(pad_out), .slew_limit(slew_limit));

    // ***********************************************************************
    // Compare tasks and bus cycles
    // ***********************************************************************
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic set_pad(input logic [7:0] v);
        @(posedge aclk);
        pad_in <= v;
        cyc(8);
    endtask

    // Address and data are offered together; each is released at the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1)
            begin
                chk_val(32'(s_axi_bresp), 32'(er), "write response");
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 100) chk_bit(1'b0, 1'b1, "write answer never came");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
            begin
                chk_val(s_axi_rdata, ed, "read data");
                chk_val(32'(s_axi_rresp), 32'(er), "read response");
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 100) chk_bit(1'b0, 1'b1, "read answer never came");
    endtask

    // A quarter-rate clock has period four: value flips after two cycles, repeats after four.
    task automatic clk_pattern();
        logic [7:0] v;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge aclk);
            v[i] = pad_out.dout[BIT_PIN6];
        end
        for (int i = 0; i < 4; i++)
        begin
            chk_bit(v[i + 2], ~v[i], "clock out half period");
            chk_bit(v[i + 4], v[i], "clock out period");
        end
    endtask

    // ***********************************************************************
    // Scenarios
    // ***********************************************************************
    task automatic t_reset();
        rd(OFF_OUTPUT_LATCH, 32'(LATCH_RESET), RESP_OKAY);
        rd(OFF_DIRECTION_A, 32'(DIR_RESET), RESP_OKAY);
        rd(OFF_ANALOG_SEL_A, 32'(ANSEL_RESET), RESP_OKAY);
        rd(OFF_SLEW_RATE, 32'(SLEW_RESET), RESP_OKAY);
        rd(OFF_OSC_CONFIG, 32'(OSC_RESET), RESP_OKAY);
        chk_val(32'(slew_limit), 32'(SLEW_RESET), "slew output");
    endtask

    task automatic t_masks();
        wr(OFF_ANALOG_SEL_A, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        rd(OFF_ANALOG_SEL_A, 32'h0000002F, RESP_OKAY);
        wr(OFF_SLEW_RATE, 32'hFFFFFFE0, 4'hF, RESP_OKAY);
        rd(OFF_SLEW_RATE, 32'h00000000, RESP_OKAY);
        cyc(3);
        chk_val(32'(slew_limit), 32'h00000000, "slew output");
        wr(OFF_OSC_CONFIG, 32'h000000FF, 4'hF, RESP_OKAY);
        rd(OFF_OSC_CONFIG, 32'h00000007, RESP_OKAY);
        wr(OFF_OSC_CONFIG, 32'h00000000, 4'hF, RESP_OKAY);
        wr(OFF_OUTPUT_LATCH, 32'h00000055, 4'hF, RESP_OKAY);
        wr(OFF_OUTPUT_LATCH, 32'h000000AA, 4'hE, RESP_OKAY);
        rd(OFF_OUTPUT_LATCH, 32'h00000055, RESP_OKAY);
        wr(8'h1C, 32'h000000FF, 4'hF, RESP_SLVERR);
        rd(8'h1C, 32'h00000000, RESP_SLVERR);
    endtask

    task automatic t_latch_dir();
        wr(OFF_ANALOG_SEL_A, 32'h00000000, 4'hF, RESP_OKAY);
        wr(OFF_OUTPUT_LATCH, 32'h000000A5, 4'hF, RESP_OKAY);
        wr(OFF_DIRECTION_A, 32'h00000000, 4'hF, RESP_OKAY);
        cyc(3);
        chk_val(32'(pad_out.dout), 32'h000000A5, "pad data");
        chk_val(32'(pad_out.oe), 32'h000000FF, "pad enable");
        wr(OFF_DIRECTION_A, 32'h000000F0, 4'hF, RESP_OKAY);
        cyc(3);
        chk_val(32'(pad_out.oe), 32'h0000000F, "pad enable");
        wr(OFF_DIRECTION_A, 32'h000000FF, 4'hF, RESP_OKAY);
        set_pad(8'h5A);
        rd(OFF_OUTPUT_LATCH, 32'h000000A5, RESP_OKAY);
        rd(OFF_PIN_LEVEL_A, 32'h0000005A, RESP_OKAY);
        set_pad(8'hC3);
        rd(OFF_PIN_LEVEL_A, 32'h000000C3, RESP_OKAY);
        wr(OFF_PIN_LEVEL_A, 32'h0000003C, 4'hF, RESP_OKAY);
        rd(OFF_OUTPUT_LATCH, 32'h0000003C, RESP_OKAY);
        wr(OFF_ANALOG_SEL_A, 32'h0000002F, 4'hF, RESP_OKAY);
        set_pad(8'hFF);
        rd(OFF_PIN_LEVEL_A, 32'h000000D0, RESP_OKAY);
        wr(OFF_ANALOG_SEL_A, 32'h00000000, 4'hF, RESP_OKAY);
    endtask

    task automatic t_osc();
        wr(OFF_OUTPUT_LATCH, 32'h000000FF, 4'hF, RESP_OKAY);
        wr(OFF_OSC_CONFIG, 32'(PAU_OSC_RC), 4'hF, RESP_OKAY);
        cyc(3);
        chk_bit(pad_out.oe[BIT_PIN6], 1'b1, "clock out enable");
        clk_pattern();
        wr(OFF_OSC_CONFIG, 32'h00000004, 4'hF, RESP_OKAY);
        rd(OFF_PIN_LEVEL_A, 32'h000000BF, RESP_OKAY);
        wr(OFF_DIRECTION_A, 32'h00000000, 4'hF, RESP_OKAY);
        cyc(3);
        chk_val(32'(pad_out.oe), 32'h000000BF, "pad enable with clock out");
        chk_val(32'(pad_out.dout), 32'h000000BF, "pad data with clock out");
        for (int m = 2; m < 4; m++)
        begin
            wr(OFF_OSC_CONFIG, 32'(m), 4'hF, RESP_OKAY);
            cyc(3);
            chk_bit(pad_out.oe[BIT_PIN7], 1'b0, "pin seven enable");
            chk_bit(pad_out.oe[BIT_PIN6], 1'b0, "pin six enable");
            rd(OFF_PIN_LEVEL_A, 32'h0000003F, RESP_OKAY);
        end
        wr(OFF_OSC_CONFIG, 32'(PAU_OSC_INTERNAL), 4'hF, RESP_OKAY);
        cyc(3);
        chk_val(32'(pad_out.oe), 32'h000000FF, "pad enable");
    endtask

    task automatic t_periph();
        wr(OFF_OUTPUT_LATCH, 32'h00000000, 4'hF, RESP_OKAY);
        wr(OFF_DIRECTION_A, 32'h000000FF, 4'hF, RESP_OKAY);
        wr(OFF_PERIPH_CTRL, 32'h00000101, 4'h3, RESP_OKAY);
        cyc(3);
        chk_bit(pad_out.oe[0], 1'b1, "peripheral enable");
        chk_bit(pad_out.dout[0], 1'b1, "peripheral data");
        wr(OFF_OUTPUT_LATCH, 32'h00000001, 4'hF, RESP_OKAY);
        wr(OFF_DIRECTION_A, 32'h00000000, 4'hF, RESP_OKAY);
        wr(OFF_PERIPH_CTRL, 32'h00000001, 4'h3, RESP_OKAY);
        cyc(3);
        chk_bit(pad_out.dout[0], 1'b0, "peripheral data");
        chk_bit(pad_out.dout[1], 1'b0, "latch data");
    endtask

    // ***********************************************************************
    // Clock, watchdog and main sequence
    // ***********************************************************************
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // The whole sequence needs well under a thousand cycles; this ceiling only cuts a hang short.
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            $display("wrong value at %0t: run did not finish in time", $time);
            stop_test();
        end
    end

    initial
    begin
        n_errors      = 0;
        n_checks      = 0;
        cycles        = 0;
        aresetn       = 1'b0;
        s_axi_awaddr  = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h00000000;
        s_axi_wstrb   = 4'h0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        pad_in        = 8'h00;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_masks();
        t_latch_dir();
        t_osc();
        t_periph();
        stop_test();
    end
endmodule
